// ===== ssl_map.svh
`ifndef SSL_MAP_SVH
`define SSL_MAP_SVH
// word shape
`define SSL_WORD_BITS     24
`define SSL_SEL_LSB       0
`define SSL_SEL_BITS      2
// latch select codes held in the two low bits
`define SSL_SEL_REF       2'h0
`define SSL_SEL_AB        2'h1
`define SSL_SEL_FUNC      2'h2
`define SSL_SEL_INIT      2'h3
// reset value of every latch
`define SSL_LATCH_RST     24'h000000
// function latch monitor select field and the lock-detect code
`define SSL_MUX_LSB       4
`define SSL_MUX_BITS      3
`define SSL_MUX_LOCK      3'h1
`define SSL_MUX_HIGH      3'h3
`define SSL_MUX_LOW       3'h7
`endif

// ===== ssl_pkg.sv
`include "ssl_map.svh"
package ssl_pkg;
   typedef logic [`SSL_WORD_BITS-1:0] ssl_word_t;
   typedef logic [`SSL_SEL_BITS-1:0]  ssl_sel_t;
   // the four latches held behind the serial port
   typedef struct packed {
      ssl_word_t ref_latch;
      ssl_word_t ab_latch;
      ssl_word_t func_latch;
      ssl_word_t init_latch;
   } ssl_latches_t;
   // one committed word with its strobe
   typedef struct packed {
      logic      valid;
      ssl_word_t word;
   } ssl_commit_t;
   // power-up write tracking
   typedef enum logic [2:0] {
      SSL_ST_WAIT   = 3'b001,
      SSL_ST_ACTIVE = 3'b010,
      SSL_ST_DOWN   = 3'b100
   } ssl_state_t;
endpackage : ssl_pkg

// ===== ssl_sync.sv
// two-flop synchroniser for a group of pin inputs
module ssl_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         sys_clk,
   input  wire logic         srst,
   // pins in, synchronised levels out
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] pin_sync
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;
   logic [W-1:0] sync_d;

   // the first stage is read only by the second
   always_comb begin
      meta_d = pin_in;
      sync_d = meta_q;
   end

   // no reset on purpose: the stages keep tracking the pins through reset,
   // so the levels are already filled at release and no false edge follows
   always_ff @(posedge sys_clk) begin
      meta_q <= meta_d;
      sync_q <= sync_d;
   end

   assign pin_sync = sync_q;
endmodule : ssl_sync

// ===== ssl_load_port.sv
`include "ssl_map.svh"
// What this block does
// [R1] write-only port: no serial readback output exists
// [R2] serial data shifted in on every rising serial clock edge while strobe is low
// [R3] rising strobe copies the 24-bit shift register into addressed latch
// [R4] low two bits pick latch: 00 reference, 01 AB, 10 function
// [R5] host keeps serial clock at or below 20 MHz
// [R6] host lowers strobe before shifting a word
// [R7] host may send a word as three bytes under one strobe-low
// [R8] host raises strobe only after the third byte
// [R9] host uses clock phase zero, data stable at rising edge
// [R10] output stays inactive until reference, N and init latches written
// [R11] chip power enable input controls power-down, driven by host
// [R12] power enable low forces power-down at once, no clock needed
// [R13] monitor output can show lock detect when so programmed
// [R14] words arrive MSB first, select bits clocked in last
module ssl_load_port
   import ssl_pkg::*;
(
   // clock and reset
   input  wire logic   sys_clk,
   input  wire logic   srst,
   // serial pins from the host
   input  wire logic   serial_clk,
   input  wire logic   serial_data_in,
   input  wire logic   latch_load_strobe,
   // power control pin
   input  wire logic   chip_enable,
   // status from the synthesizer core
   input  wire logic   lock_detect,
   // monitor pin and core controls
   output logic        muxed_monitor_out,
   output logic        output_active,
   output logic        powered_down,
   output ssl_latches_t latches,
   output ssl_commit_t  commit
);
   // sync all pins for the logic; raw chip_enable also drives outputs (R5 keeps serial clock well under sys_clk/4)
   logic [3:0] pins_s;
   ssl_sync #(.W(4)) u_sync (
      .sys_clk  (sys_clk),
      .srst     (srst),
      .pin_in   ({chip_enable, serial_clk, serial_data_in,
                  latch_load_strobe}),
      .pin_sync (pins_s)
   ); // [R5]

   logic sclk_s;
   logic sdat_s;
   logic le_s;
   logic ce_s;
   assign ce_s   = pins_s[3];
   assign sclk_s = pins_s[2];
   assign sdat_s = pins_s[1];
   assign le_s   = pins_s[0];

   // edge detect state
   logic sclk_prev_q, sclk_prev_d;
   logic le_prev_q, le_prev_d;
   logic sclk_rise;
   logic le_rise;
   assign sclk_rise = sclk_s & ~sclk_prev_q;
   assign le_rise   = le_s & ~le_prev_q;

   // shift register and latches
   ssl_word_t    shift_q, shift_d;
   ssl_latches_t lat_q, lat_d;
   ssl_commit_t  commit_q, commit_d;
   logic         ref_seen_q, ref_seen_d;
   logic         ab_seen_q, ab_seen_d;
   logic         init_seen_q, init_seen_d;
   ssl_state_t   st_q, st_d;
   logic         mon_q, mon_d;

   // select code of a word
   function automatic ssl_sel_t word_sel(input ssl_word_t w);
      word_sel = w[`SSL_SEL_LSB +: `SSL_SEL_BITS];
   endfunction : word_sel

   // shifting and latching; sampling only while strobe low protects
   // a committed word from clocks seen after the strobe rises
   always_comb begin
      sclk_prev_d = sclk_s;
      le_prev_d   = le_s;
      shift_d     = shift_q;
      lat_d       = lat_q;
      commit_d    = '0;
      ref_seen_d  = ref_seen_q;
      ab_seen_d   = ab_seen_q;
      init_seen_d = init_seen_q;
      if (sclk_rise && !le_s) begin
         // msb first: new bit enters at the bottom
         shift_d = {shift_q[`SSL_WORD_BITS-2:0], sdat_s}; // [R2] [R14] [R6]
      end
      if (le_rise) begin
         commit_d.valid = 1'b1; // [R3] [R8]
         commit_d.word  = shift_q;
         unique case (word_sel(shift_q)) // [R4]
            `SSL_SEL_REF: begin
               lat_d.ref_latch = shift_q;
               ref_seen_d      = 1'b1;
            end
            `SSL_SEL_AB: begin
               lat_d.ab_latch = shift_q;
               ab_seen_d      = 1'b1;
            end
            `SSL_SEL_FUNC: begin
               lat_d.func_latch = shift_q;
            end
            `SSL_SEL_INIT: begin
               // init word also loads the function settings
               lat_d.init_latch = shift_q;
               lat_d.func_latch = shift_q;
               init_seen_d      = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sclk_prev_q <= 1'b0;
         le_prev_q   <= 1'b1; // strobe idles high: no false rise
         shift_q     <= `SSL_LATCH_RST;
         lat_q       <= {4{`SSL_LATCH_RST}};
         commit_q    <= '0;
         ref_seen_q  <= 1'b0;
         ab_seen_q   <= 1'b0;
         init_seen_q <= 1'b0;
      end else begin
         sclk_prev_q <= sclk_prev_d;
         le_prev_q   <= le_prev_d;
         shift_q     <= shift_d;
         lat_q       <= lat_d;
         commit_q    <= commit_d;
         ref_seen_q  <= ref_seen_d;
         ab_seen_q   <= ab_seen_d;
         init_seen_q <= init_seen_d;
      end
   end

   // activity state: waits for the three power-up writes
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         SSL_ST_WAIT: begin
            if (ref_seen_q && ab_seen_q && init_seen_q) begin
               st_d = SSL_ST_ACTIVE; // [R10]
            end
         end
         SSL_ST_ACTIVE: begin
            if (!ce_s) begin
               st_d = SSL_ST_DOWN; // [R11]
            end
         end
         SSL_ST_DOWN: begin
            // latches keep their contents across power-down
            if (ce_s) begin
               st_d = SSL_ST_ACTIVE; // [R11]
            end
         end
         default: st_d = SSL_ST_WAIT;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_q <= SSL_ST_WAIT;
      end else begin
         st_q <= st_d;
      end
   end

   // monitor selection from the function latch
   always_comb begin
      unique case (lat_q.func_latch[`SSL_MUX_LSB +: `SSL_MUX_BITS])
         `SSL_MUX_LOCK: mon_d = lock_detect; // [R13]
         `SSL_MUX_HIGH: mon_d = 1'b1;
         default:       mon_d = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         mon_q <= 1'b0;
      end else begin
         mon_q <= mon_d;
      end
   end

   // chip_enable gates powered_down and output_active combinationally so power-down is
   // immediate; trade-off: an unsynchronised pin reaches outputs
   assign powered_down      = ~chip_enable; // [R12]
   assign output_active     = chip_enable & (st_q == SSL_ST_ACTIVE); // [R10]
   assign muxed_monitor_out = mon_q;
   assign latches           = lat_q;
   assign commit            = commit_q;
   // no serial output pin exists: readback is impossible [R1]
endmodule : ssl_load_port

// ===== ssl_load_port_checker.sv
module ssl_load_port_checker
   import ssl_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // pins and outputs watched
   input wire logic latch_load_strobe,
   input wire logic chip_enable,
   input wire logic lock_detect,
   input wire logic muxed_monitor_out,
   input wire logic output_active,
   input wire logic powered_down,
   input wire ssl_latches_t latches,
   input wire ssl_commit_t commit
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   // commit timing and latch steering, sync delay allows one cycle slack
   commit_rise_a: assert property (
      $rose(latch_load_strobe) |-> ##[3:4] commit.valid) else $error("no commit");
   commit_pulse_a: assert property (commit.valid |=> !commit.valid)
      else $error("commit too long");
   ref_load_a: assert property (commit.valid && commit.word[1:0] == 2'h0
      |-> latches.ref_latch == commit.word) else $error("ref latch wrong");
   func_load_a: assert property (commit.valid && commit.word[1:0] == 2'h2
      |-> latches.func_latch == commit.word) else $error("func latch wrong");
   latch_hold_a: assert property (
      !$stable(latches) && !$past(srst) |-> commit.valid)
      else $error("latch moved without commit");
   // power pin acts without waiting for the clock
   pd_pin_a: assert property (powered_down == !chip_enable)
      else $error("power-down not on pin");
   pd_quiet_a: assert property (!chip_enable |-> !output_active)
      else $error("active while powered down");
   mon_lock_a: assert property (latches.func_latch[6:4] == 3'h1
      |=> muxed_monitor_out == $past(lock_detect)) else $error("lock not shown");
   cover property (commit.valid && commit.word[1:0] == 2'h3);
   cover property ($rose(output_active));
   cover property (powered_down && latches.ref_latch != 24'h000000);
endmodule : ssl_load_port_checker

bind ssl_load_port ssl_load_port_checker ssl_load_port_checker_inst (
   .sys_clk, .srst, .latch_load_strobe, .chip_enable, .lock_detect,
   .muxed_monitor_out, .output_active, .powered_down, .latches, .commit);

// ===== ssl_host_model.sv
module ssl_host_model
   import ssl_pkg::*;
(
   // serial pins toward the port
   output logic serial_clk,
   output logic serial_data_in,
   output logic latch_load_strobe
);
   timeunit 1ns;
   timeprecision 100ps;
   // idle: clock parked low between frames, strobe high
   initial begin
      serial_clk = 1'b0;
      serial_data_in = 1'b0;
      latch_load_strobe = 1'b1;
   end
   // three bytes under one strobe-low, data moves on the falling clock
   task automatic send_word(input ssl_word_t w);
      latch_load_strobe = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         serial_data_in = w[i];
         #62.5 serial_clk = 1'b1;
         #62.5 serial_clk = 1'b0;
      end
      // released line flips so a stale bit never matches by chance
      serial_data_in = ~w[0];
      #62.5 latch_load_strobe = 1'b1;
      #100;
   endtask : send_word
endmodule : ssl_host_model

// ===== test_ssl_load_port.sv
module test_ssl_load_port
   import ssl_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // word to send, then active and monitor levels it should leave
   typedef struct {ssl_word_t w; logic act; logic mon;} ssl_row_t;
   ssl_row_t rows [5] = '{'{24'hA55A00, 1'b0, 1'b0},
      '{24'h3CC3C1, 1'b0, 1'b0}, '{24'h0FF033, 1'b1, 1'b1},
      '{24'h000072, 1'b1, 1'b0}, '{24'h000016, 1'b1, 1'b1}};
   logic sys_clk, srst, serial_clk, serial_data_in, latch_load_strobe;
   logic chip_enable, lock_detect, muxed_monitor_out, output_active;
   logic powered_down;
   ssl_latches_t latches;
   ssl_commit_t commit;
   int fails, checks;
   ssl_load_port ssl_load_port_inst (.sys_clk, .srst, .serial_clk,
      .serial_data_in, .latch_load_strobe, .chip_enable, .lock_detect,
      .muxed_monitor_out, .output_active, .powered_down, .latches, .commit);
   ssl_host_model ssl_host_model_inst (.serial_clk, .serial_data_in,
      .latch_load_strobe);
   // compare helpers, one per result width
   task automatic check_bit(input string n, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("BAD %s exp %b got %b", n, e, g);
      end
   endtask : check_bit
   task automatic check_word(input string n, input ssl_word_t e,
                             input ssl_word_t g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask : check_word
   task automatic tally_and_finish;
      if (fails == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish
   // free-running system clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // the whole run needs about 20 us, so 60 us means a hang
   initial begin
      #60us;
      fails++;
      tally_and_finish();
   end
   // main sequence: rows first, then lock, power and reset cases
   initial begin
      srst = 1'b1;
      chip_enable = 1'b1;
      lock_detect = 1'b1;
      repeat (8) @(posedge sys_clk);
      @(negedge sys_clk) srst = 1'b0;
      repeat (4) @(negedge sys_clk);
      check_bit("active", 1'b0, output_active);
      foreach (rows[i]) begin
         ssl_host_model_inst.send_word(rows[i].w);
         @(negedge sys_clk);
         check_word("latch", rows[i].w,
                    latches[95 - 24 * rows[i].w[1:0] -: 24]);
         check_bit("active", rows[i].act, output_active);
         check_bit("monitor", rows[i].mon, muxed_monitor_out);
      end
      lock_detect = 1'b0;
      repeat (2) @(negedge sys_clk);
      check_bit("monitor", 1'b0, muxed_monitor_out);
      // power-down must land before the next clock edge
      chip_enable = 1'b0;
      #1;
      check_bit("pd", 1'b1, powered_down);
      check_bit("active", 1'b0, output_active);
      @(negedge sys_clk) chip_enable = 1'b1;
      repeat (3) @(negedge sys_clk);
      check_bit("active", 1'b1, output_active);
      @(negedge sys_clk) srst = 1'b1;
      @(negedge sys_clk) srst = 1'b0;
      check_word("ref", 24'h000000, latches.ref_latch);
      check_bit("active", 1'b0, output_active);
      repeat (3) @(negedge sys_clk);
      ssl_host_model_inst.send_word(24'h123456);
      @(negedge sys_clk);
      check_word("func", 24'h123456, latches.func_latch);
      check_word("ref", 24'h000000, latches.ref_latch);
      tally_and_finish();
   end
endmodule : test_ssl_load_port
